// [verification/qdp_mac_model.sv]
`timescale 1ns/1ps

module qdp_mac_model
(
  input  wire logic        core_clk, // Device clock.
  output logic      [10:0] txRdAddr, // Transmit queue read address.
  input  wire logic [7:0]  txRdData, // Transmit queue byte, one cycle late.
  output logic             rxWrEn,   // Receive queue byte write.
  output logic      [10:0] rxWrAddr, // Receive queue byte address.
  output logic      [7:0]  rxWrData  // Receive queue byte.
);
  initial
  begin
    txRdAddr = 11'h000;
    rxWrEn   = 1'h0;
    rxWrAddr = 11'h000;
    rxWrData = 8'h00;
  end

  // ==================
  // Receive side. Idle lines are scrambled so that a stale value is never mistaken for fresh data.
  task automatic put(input logic [10:0] a, input logic [7:0] d, input int gap);
    repeat (gap) @(posedge core_clk);
    @(posedge core_clk);
    rxWrEn   <= 1'h1;
    rxWrAddr <= a;
    rxWrData <= d;
    @(posedge core_clk);
    rxWrEn   <= 1'h0;
    rxWrAddr <= ~a;
    rxWrData <= ~d;
  endtask

  // ==================
  // Transmit side.
  task automatic get(input logic [10:0] a, output logic [7:0] d);
    @(posedge core_clk);
    txRdAddr <= a;
    @(posedge core_clk);
    @(posedge core_clk);
    d = txRdData;
    txRdAddr <= ~a;
  endtask
endmodule

// [verification/tb.sv]
`timescale 1ns/1ps

module tb;
  import qdp_pkg::*;
  logic        core_clk;
  logic        arst_n;
  qdp_wb_req_t wbReq;
  qdp_wb_rsp_t wbRsp;
  logic [10:0] txRdAddr;
  logic [7:0]  txRdData;
  logic        rxWrEn;
  logic [10:0] rxWrAddr;
  logic [7:0]  rxWrData;
  logic [8:0]  irqEvent;
  logic        irqOut;
  logic [31:0] rd;
  logic [7:0]  b;
  int          errCount;
  int          checked;
  logic [7:0]  txExp [10] = '{8'hAA, 8'hBB, 8'hCC, 8'h11, 8'h22, 8'h33, 8'h44, 8'hEE, 8'h34, 8'h12};

  qdp_queue_port i_qdp_queue_port
  (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .wbReq    (wbReq),
    .wbRsp    (wbRsp),
    .txRdAddr (txRdAddr),
    .txRdData (txRdData),
    .rxWrEn   (rxWrEn),
    .rxWrAddr (rxWrAddr),
    .rxWrData (rxWrData),
    .irqEvent (irqEvent),
    .irqOut   (irqOut)
  );

  qdp_mac_model mac
  (
    .core_clk (core_clk),
    .txRdAddr (txRdAddr),
    .txRdData (txRdData),
    .rxWrEn   (rxWrEn),
    .rxWrAddr (rxWrAddr),
    .rxWrData (rxWrData)
  );

  initial core_clk = 1'h0;
  always #5 core_clk = ~core_clk;

  // ==================
  // Bus and checking tasks.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errCount++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
    @(posedge core_clk);
    wbReq <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: adr, sel: sel, dat: dat};
    // Only the watchdog ends a wait for an answer that never comes.
    do
    begin
      @(posedge core_clk);
    end
    while (wbRsp.ack !== 1'h1);
    rd = wbRsp.dat;
    wbReq <= '0;
  endtask

  task automatic rdchk(input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] exp);
    wb(1'h0, adr, sel, 32'h0000_0000);
    check(rd, exp);
  endtask

  task automatic pulse(input int i);
    @(posedge core_clk);
    irqEvent <= 9'h001 << i;
    @(posedge core_clk);
    irqEvent <= 9'h000;
    repeat (2) @(posedge core_clk);
  endtask

  task automatic give_verdict;
    if (errCount == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==================
  // Main sequence.
  initial
  begin
    arst_n   = 1'h0;
    wbReq    = '0;
    irqEvent = 9'h000;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'h1;
    rdchk(8'h40, 4'hF, 32'h0000_0000);
    rdchk(8'h44, 4'hF, 32'h0000_0300);
    check({31'h0, irqOut}, 32'h0000_0000);
    wb(1'h1, 8'h40, 4'hF, 32'hFFFF_FFFF);
    rdchk(8'h40, 4'hF, 32'h0000_FF80);
    rdchk(8'h80, 4'hF, 32'h0000_0000);
    wb(1'h1, 8'h44, 4'hF, 32'h0000_FF80);
    // Each enable alone must pass its own source and block a neighbour.
    for (int i = 0; i < 9; i++)
    begin
      wb(1'h1, 8'h40, 4'hF, 32'h0000_0080 << i);
      pulse((i + 1) % 9);
      check({31'h0, irqOut}, 32'h0000_0000);
      pulse(i);
      check({31'h0, irqOut}, 32'h0000_0001);
      rdchk(8'h44, 4'hF, (32'h0000_0080 << i) | (32'h0000_0080 << ((i + 1) % 9)));
      rdchk(8'h44, 4'hF, (32'h0000_0080 << i) | (32'h0000_0080 << ((i + 1) % 9)));
      check({31'h0, irqOut}, 32'h0000_0001);
      wb(1'h1, 8'h44, 4'hF, 32'h0000_FF80);
      @(posedge core_clk);
      check({31'h0, irqOut}, 32'h0000_0000);
    end
    // A clear taken in the same cycle as an event must leave that event's bit set.
    fork
      wb(1'h1, 8'h44, 4'hF, 32'h0000_FF80);
      begin
        @(posedge core_clk);
        irqEvent <= 9'h001;
        @(posedge core_clk);
        irqEvent <= 9'h000;
      end
    join
    rdchk(8'h44, 4'hF, 32'h0000_0080);
    wb(1'h1, 8'h44, 4'hF, 32'h0000_FF80);
    // Mixed widths from an odd pointer; the last write has a split lane set and must be dropped.
    wb(1'h1, 8'h04, 4'h3, 32'h0000_4003);
    wb(1'h1, 8'h08, 4'h1, 32'h0000_00AA);
    wb(1'h1, 8'h08, 4'h3, 32'h0000_CCBB);
    wb(1'h1, 8'h08, 4'hF, 32'h4433_2211);
    wb(1'h1, 8'h08, 4'h4, 32'h00EE_0000);
    wb(1'h1, 8'h08, 4'hC, 32'h1234_0000);
    wb(1'h1, 8'h08, 4'h5, 32'h0099_0099);
    rdchk(8'h04, 4'hF, 32'h0000_400D);
    for (int i = 0; i < 10; i++)
    begin
      mac.get(11'(3 + i), b);
      check({24'h0, b}, {24'h0, txExp[i]});
    end
    wb(1'h1, 8'h04, 4'h3, 32'h0000_0100);
    wb(1'h1, 8'h08, 4'h1, 32'h0000_0077);
    wb(1'h1, 8'h08, 4'h1, 32'h0000_0066);
    rdchk(8'h04, 4'hF, 32'h0000_0100);
    mac.get(11'h100, b);
    check({24'h0, b}, 32'h0000_0066);
    // Receive reads straddle the top of the queue to exercise pointer wrap.
    for (int i = 0; i < 8; i++)
      mac.put(11'(11'h7FE + i), 8'(8'hA0 + i), i % 3);
    wb(1'h1, 8'h04, 4'hC, 32'h47FE_0000);
    rdchk(8'h08, 4'h3, 32'h0000_A1A0);
    rdchk(8'h08, 4'hF, 32'hA5A4_A3A2);
    rdchk(8'h08, 4'h2, 32'h0000_A600);
    rdchk(8'h08, 4'h8, 32'hA700_0000);
    rdchk(8'h04, 4'hF, 32'h4006_0100);
    // A reset in mid-run must clear an enable register that software had set.
    arst_n <= 1'h0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'h1;
    rdchk(8'h40, 4'hF, 32'h0000_0000);
    rdchk(8'h44, 4'hF, 32'h0000_0300);
    give_verdict();
  end

  initial
  begin
    #500_000;
    errCount++;
    give_verdict();
  end
endmodule

// [verilog/qdp_frame_ram.sv]
`timescale 1ns/1ps

module qdp_frame_ram
(
  input  wire logic        core_clk,   // Device clock.
  input  wire logic        arst_n,     // Asynchronous reset, active low.
  input  wire logic        hostWe,     // Host writes hostCnt bytes at hostPtr.
  input  wire logic [10:0] hostPtr,    // Byte pointer of first host byte.
  input  wire logic [2:0]  hostCnt,    // Number of bytes, 1 to 4.
  input  wire logic [31:0] hostWrData, // First byte in bits 7:0.
  output logic      [31:0] hostRdData, // Bytes at hostPtr upward, unregistered.
  input  wire logic        sideWe,     // MAC side byte write.
  input  wire logic [10:0] sideAddr,   // MAC side byte address.
  input  wire logic [7:0]  sideWrData, // MAC side write byte.
  output logic      [7:0]  sideRdData  // MAC side read byte, registered.
);

  // ==========================================================================
  // Byte-wide storage so that any pointer alignment needs no lane rotation.
  logic [7:0] mem [0:2047];

  always_ff @(posedge core_clk)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (hostWe && (3'(i) < hostCnt))
      begin
        mem[hostPtr + 11'(i)] <= hostWrData[8*i +: 8];
      end
    end
    if (sideWe)
    begin
      mem[sideAddr] <= sideWrData;
    end
  end

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      hostRdData[8*i +: 8] = mem[hostPtr + 11'(i)];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sideRdData <= 8'h00;
    end
    else
    begin
      sideRdData <= mem[sideAddr];
    end
  end

endmodule

// [verilog/qdp_irq_ctrl.sv]
`timescale 1ns/1ps
`include "qdp_map.svh"

module qdp_irq_ctrl
(
  input  wire logic       core_clk, // Device clock.
  input  wire logic       arst_n,   // Asynchronous reset, active low.
  input  wire logic [8:0] evt,      // Source event pulses, index 0 is bit 7.
  input  wire logic       clrWe,    // Status write strobe.
  input  wire logic [8:0] clrMask,  // Ones clear status bits.
  input  wire logic [8:0] enable,   // Enable bits from the enable register.
  output logic      [8:0] status,   // Sticky status bits.
  output logic            irqOut    // Level interrupt, registered.
);
  import qdp_pkg::*;

  qdp_irq_state_t st_ff;
  qdp_irq_state_t nxt_st;

  // ==========================================================================
  // An event in the cycle of its clear still sets the bit.
  always_comb
  begin
    nxt_st        = st_ff;
    nxt_st.status = (st_ff.status & ~(clrWe ? clrMask : 9'h000)) | evt;
    nxt_st.irq    = |(st_ff.status & enable);
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_ff <= '{status: `QDP_ISR_RST, irq: 1'b0};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign status = st_ff.status;
  assign irqOut = st_ff.irq;

  // ==========================================================================
  chk_irq_gate: assert property (@(posedge core_clk) disable iff (!arst_n)
    ##1 irqOut == |($past(status) & $past(enable)))
    else $error("interrupt output does not follow enabled status");

  chk_status_sticky: assert property (@(posedge core_clk) disable iff (!arst_n)
    (status != 9'h000) && !clrWe |=> ((status & $past(status)) == $past(status)))
    else $error("status bit cleared without a write of one");

  chk_set_wins: assert property (@(posedge core_clk) disable iff (!arst_n)
    clrWe && (evt != 9'h000) |=> ((status & $past(evt)) == $past(evt)))
    else $error("event lost in the cycle of its clear");

  cov_irq_rise: cover property (@(posedge core_clk) disable iff (!arst_n)
    $rose(irqOut));

endmodule

// [verilog/qdp_map.svh]
`ifndef QDP_MAP_SVH
`define QDP_MAP_SVH

// ==========================================================================
// Register byte addresses on the 32-bit Wishbone port.
`define QDP_ADR_PTR        8'h04
`define QDP_ADR_DATA       8'h08
`define QDP_ADR_IER        8'h40
`define QDP_ADR_ISR        8'h44

// ==========================================================================
// Byte lanes inside the data word: low data word in lanes 0-1, high in 2-3.
`define QDP_DATA_LOW_LANE  2'h0
`define QDP_DATA_HIGH_LANE 2'h2

// ==========================================================================
// Field positions.
`define QDP_PTR_AUTO_BIT   14
`define QDP_PTR_MSB        10
`define QDP_RX_PTR_LSB     16
`define QDP_IRQ_LSB        7
`define QDP_IRQ_MSB        15

// ==========================================================================
// Reset values.
`define QDP_PTR_RST        11'h000
`define QDP_IER_RST        9'h000
`define QDP_ISR_RST        9'h006

`endif

// [verilog/qdp_pkg.sv]
package qdp_pkg;

  // ==========================================================================
  // Bus carriers.
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } qdp_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } qdp_wb_rsp_t;

  // ==========================================================================
  // Module state.
  typedef struct packed {
    logic        ack;
    logic [31:0] rdat;
    logic [10:0] txPtr;
    logic        txAuto;
    logic [10:0] rxPtr;
    logic        rxAuto;
    logic [8:0]  interrupt_enable;
  } qdp_top_state_t;

  typedef struct packed {
    logic [8:0] status;
    logic       irq;
  } qdp_irq_state_t;

endpackage

// [verilog/qdp_queue_port.sv]
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "qdp_map.svh"

module qdp_queue_port
(
  input  wire logic                 core_clk, // Device clock, 100 MHz.
  input  wire logic                 arst_n,   // Asynchronous reset, active low.
  input  wire qdp_pkg::qdp_wb_req_t wbReq,    // Wishbone request.
  output qdp_pkg::qdp_wb_rsp_t      wbRsp,    // Wishbone answer, registered.
  input  wire logic [10:0]          txRdAddr, // MAC reads transmit queue here.
  output logic      [7:0]           txRdData, // Transmit queue byte, registered.
  input  wire logic                 rxWrEn,   // MAC writes a receive byte.
  input  wire logic [10:0]          rxWrAddr, // Receive queue byte address.
  input  wire logic [7:0]           rxWrData, // Receive queue byte.
  input  wire logic [8:0]           irqEvent, // Source pulses, index 0 is bit 7.
  output logic                      irqOut    // Level interrupt, registered.
);
  import qdp_pkg::*;

  // ==========================================================================
  // Lane decoding shared by data path and checks.
  function automatic logic [1:0] laneFirst(input logic [3:0] sel);
    logic [1:0] f;
    f = 2'h0;
    for (int i = 3; i >= 0; i--)
    begin
      if (sel[i])
      begin
        f = 2'(i);
      end
    end
    return f;
  endfunction

  function automatic logic [2:0] laneCount(input logic [3:0] sel);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < 4; i++)
    begin
      n = n + {2'b00, sel[i]};
    end
    return n;
  endfunction

  // Only single lanes, the lane pairs 0-1 and 2-3, or all four lanes are a legal data access.
  function automatic logic selLegal(input logic [3:0] sel);
    case (sel)
      4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  qdp_top_state_t st_ff;
  qdp_top_state_t nxt_st;

  logic        reqNew;
  logic        isData;
  logic        txWe;
  logic [31:0] hostWrData;
  logic [31:0] rxRdData;
  logic [31:0] lanePut;
  logic [31:0] laneMask;
  logic [1:0]  first;
  logic [2:0]  count;
  logic        isrWe;
  logic [8:0]  isrClr;
  logic [8:0]  isrStatus;
  logic        irqLevel;
  logic [7:0]  txSide;

  assign reqNew = wbReq.cyc && wbReq.stb && !st_ff.ack;
  assign first  = laneFirst(wbReq.sel);
  assign count  = laneCount(wbReq.sel);
  assign isData = ({wbReq.adr[7:2], 2'b00} == `QDP_ADR_DATA) && selLegal(wbReq.sel);

  // ==========================================================================
  // Host bytes are packed with the lowest selected lane at the pointer.
  assign hostWrData = wbReq.dat >> {first, 3'b000};
  assign lanePut    = rxRdData << {first, 3'b000};
  assign laneMask   = {{8{wbReq.sel[3]}}, {8{wbReq.sel[2]}}, {8{wbReq.sel[1]}}, {8{wbReq.sel[0]}}};

  // ==========================================================================
  // Request decode and register file.
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.ack = 1'b0;
    txWe = 1'b0;
    isrWe = 1'b0;
    isrClr = 9'h000;
    if (reqNew)
    begin
      nxt_st.ack  = 1'b1;
      nxt_st.rdat = 32'h0000_0000;
      if (isData)
      begin
        if (wbReq.we)
        begin
          txWe = 1'b1;
          if (st_ff.txAuto)
          begin
            nxt_st.txPtr = st_ff.txPtr + {8'h00, count};
          end
        end
        else
        begin
          nxt_st.rdat = lanePut & laneMask;
          if (st_ff.rxAuto)
          begin
            nxt_st.rxPtr = st_ff.rxPtr + {8'h00, count};
          end
        end
      end
      else
      begin
        case ({wbReq.adr[7:2], 2'b00})
          `QDP_ADR_PTR:
          begin
            if (wbReq.we)
            begin
              if (wbReq.sel[0])
              begin
                nxt_st.txPtr[7:0] = wbReq.dat[7:0];
              end
              if (wbReq.sel[1])
              begin
                nxt_st.txPtr[10:8] = wbReq.dat[10:8];
                nxt_st.txAuto      = wbReq.dat[`QDP_PTR_AUTO_BIT];
              end
              if (wbReq.sel[2])
              begin
                nxt_st.rxPtr[7:0] = wbReq.dat[23:16];
              end
              if (wbReq.sel[3])
              begin
                nxt_st.rxPtr[10:8] = wbReq.dat[26:24];
                nxt_st.rxAuto      = wbReq.dat[`QDP_RX_PTR_LSB + `QDP_PTR_AUTO_BIT];
              end
            end
            else
            begin
              nxt_st.rdat[`QDP_PTR_MSB:0] = st_ff.txPtr;
              nxt_st.rdat[`QDP_PTR_AUTO_BIT] = st_ff.txAuto;
              nxt_st.rdat[`QDP_RX_PTR_LSB +: 11] = st_ff.rxPtr;
              nxt_st.rdat[`QDP_RX_PTR_LSB + `QDP_PTR_AUTO_BIT] = st_ff.rxAuto;
            end
          end
          `QDP_ADR_IER:
          begin
            if (wbReq.we)
            begin
              if (wbReq.sel[0])
              begin
                nxt_st.interrupt_enable[0] = wbReq.dat[`QDP_IRQ_LSB];
              end
              if (wbReq.sel[1])
              begin
                nxt_st.interrupt_enable[8:1] = wbReq.dat[`QDP_IRQ_MSB:8];
              end
            end
            else
            begin
              nxt_st.rdat[`QDP_IRQ_MSB:`QDP_IRQ_LSB] = st_ff.interrupt_enable;
            end
          end
          `QDP_ADR_ISR:
          begin
            if (wbReq.we)
            begin
              isrWe     = 1'b1;
              isrClr[0] = wbReq.sel[0] && wbReq.dat[`QDP_IRQ_LSB];
              isrClr[8:1] = wbReq.sel[1] ? wbReq.dat[`QDP_IRQ_MSB:8] : 8'h00;
            end
            else
            begin
              nxt_st.rdat[`QDP_IRQ_MSB:`QDP_IRQ_LSB] = isrStatus;
            end
          end
          default:
          begin
            nxt_st.rdat = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_ff <= '{ack: 1'b0, rdat: 32'h0000_0000, txPtr: `QDP_PTR_RST, txAuto: 1'b0,
                 rxPtr: `QDP_PTR_RST, rxAuto: 1'b0, interrupt_enable: `QDP_IER_RST};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // Queues and interrupt logic.
  qdp_frame_ram u_txq
  (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .hostWe     (txWe),
    .hostPtr    (st_ff.txPtr),
    .hostCnt    (count),
    .hostWrData (hostWrData),
    .hostRdData (),
    .sideWe     (1'b0),
    .sideAddr   (txRdAddr),
    .sideWrData (8'h00),
    .sideRdData (txSide)
  );

  qdp_frame_ram u_rxq
  (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .hostWe     (1'b0),
    .hostPtr    (st_ff.rxPtr),
    .hostCnt    (count),
    .hostWrData (32'h0000_0000),
    .hostRdData (rxRdData),
    .sideWe     (rxWrEn),
    .sideAddr   (rxWrAddr),
    .sideWrData (rxWrData),
    .sideRdData ()
  );

  qdp_irq_ctrl u_irq
  (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .evt      (irqEvent),
    .clrWe    (isrWe),
    .clrMask  (isrClr),
    .enable   (st_ff.interrupt_enable),
    .status   (isrStatus),
    .irqOut   (irqLevel)
  );

  assign wbRsp.ack = st_ff.ack;
  assign wbRsp.dat = st_ff.rdat;
  assign txRdData  = txSide;
  assign irqOut    = irqLevel;

  // ==========================================================================
  // Checks.
  chk_ack_pulse: assert property (@(posedge core_clk) disable iff (!arst_n)
    wbRsp.ack |=> !wbRsp.ack)
    else $error("ack held longer than one cycle");

  chk_ack_latency: assert property (@(posedge core_clk) disable iff (!arst_n)
    reqNew |=> wbRsp.ack)
    else $error("request not answered in one cycle");

  chk_tx_advance: assert property (@(posedge core_clk) disable iff (!arst_n)
    reqNew && isData && wbReq.we
    |=> st_ff.txPtr == ($past(st_ff.txAuto) ? $past(st_ff.txPtr) + {8'h00, $past(count)} : $past(st_ff.txPtr)))
    else $error("transmit pointer advanced wrongly");

  chk_rx_advance: assert property (@(posedge core_clk) disable iff (!arst_n)
    reqNew && isData && !wbReq.we
    |=> st_ff.rxPtr == ($past(st_ff.rxAuto) ? $past(st_ff.rxPtr) + {8'h00, $past(count)} : $past(st_ff.rxPtr)))
    else $error("receive pointer advanced wrongly");

  chk_write_to_tx: assert property (@(posedge core_clk) disable iff (!arst_n)
    txWe |-> reqNew && wbReq.we && isData)
    else $error("transmit queue written outside a data write");

  chk_read_from_rx: assert property (@(posedge core_clk) disable iff (!arst_n)
    reqNew && isData && !wbReq.we |=> wbRsp.dat == ($past(lanePut) & $past(laneMask)))
    else $error("data read not taken from receive queue");

  chk_ier_reserved: assert property (@(posedge core_clk) disable iff (!arst_n)
    reqNew && !wbReq.we && ({wbReq.adr[7:2], 2'b00} == `QDP_ADR_IER) |=> wbRsp.dat[6:0] == 7'h00)
    else $error("reserved enable bits not zero");

  chk_ier_update: assert property (@(posedge core_clk) disable iff (!arst_n)
    reqNew && wbReq.we && (wbReq.sel[1:0] == 2'h3) && ({wbReq.adr[7:2], 2'b00} == `QDP_ADR_IER)
    |=> st_ff.interrupt_enable == 9'($past(wbReq.dat) >> `QDP_IRQ_LSB))
    else $error("enable register not written");

  chk_isr_no_rc: assert property (@(posedge core_clk) disable iff (!arst_n)
    reqNew && !wbReq.we && ({wbReq.adr[7:2], 2'b00} == `QDP_ADR_ISR)
    |=> (isrStatus & $past(isrStatus)) == $past(isrStatus))
    else $error("status cleared by a read");

  cov_data_write: cover property (@(posedge core_clk) disable iff (!arst_n)
    reqNew && isData && wbReq.we && st_ff.txAuto ##2 reqNew && isData && wbReq.we);

  cov_data_read_odd: cover property (@(posedge core_clk) disable iff (!arst_n)
    reqNew && isData && !wbReq.we && st_ff.rxPtr[0] && (count == 3'h4));

  cov_mixed_sizes: cover property (@(posedge core_clk) disable iff (!arst_n)
    reqNew && isData && (count == 3'h1) ##[1:8] reqNew && isData && (count == 3'h2));

endmodule
